// ### include/cfg_regs_pkg.sv
// package: field layout, reset values and command codes of the
// function and read parameter registers.
// assumes: an upstream command decoder hands over opcodes and data bytes.
package cfg_regs_pkg;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int FN_RST_DIS_BIT = 0;
  localparam int FN_TBS_BIT     = 1;
  localparam int FN_PROGRAM_SUSPENDED_FLAG_BIT    = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG_BIT    = 3;
  localparam int FN_IRL_LSB     = 4;
  localparam int FN_IRL_MSB     = 7;
  localparam int RP_ROLE_BIT    = 7;
  localparam int RP_DUMMY_MSB   = 6;
  localparam int RP_DUMMY_LSB   = 3;
  localparam int RP_WRAP_BIT    = 2;
  localparam int RP_BURST_MSB   = 1;
  localparam int RP_BURST_LSB   = 0;

  // ********************************************************
  // reset values and command codes
  // ********************************************************
  localparam logic [7:0] FN_RESET_VAL  = 8'h00;
  localparam logic [7:0] RP_RESET_VAL  = 8'h00;
  localparam logic [7:0] CMD_WR_FUNC   = 8'h42;
  localparam logic [7:0] CMD_SRP_PERS  = 8'h65;
  localparam logic [7:0] CMD_SRP_WORK0 = 8'hc0;
  localparam logic [7:0] CMD_SRP_WORK1 = 8'h63;
  localparam logic [3:0] DUMMY_DEFAULT = 4'h0;

  // burst length encodings in bytes
  localparam logic [6:0] BURST_8  = 7'h08;
  localparam logic [6:0] BURST_16 = 7'h10;
  localparam logic [6:0] BURST_32 = 7'h20;
  localparam logic [6:0] BURST_64 = 7'h40;

  // register write request from the command decoder
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] data;
  } reg_wr_t;

  // decoded read behaviour
  typedef struct packed {
    logic [3:0] dummy_cycles;
    logic       use_default_dummy;
    logic       wrap_in_burst;
    logic [6:0] burst_bytes;
  } read_cfg_t;

  // shared hold/reset pin roles
  typedef enum logic [1:0] {
    PIN_HOLD  = 2'b00,
    PIN_RESET = 2'b01,
    PIN_DATA3 = 2'b10
  } pin_role_t;

endpackage

// ### src/cfg_regs.sv
// file: function register and read parameter register pair of a
// serial flash, with derived pin roles and read behaviour.
// assumes: commands are already decoded and write enable checked;
// suspend/resume events come from the program/erase controller.
`timescale 1ns/1ps

// ********************************************************
// suspend status flag
// ********************************************************
// set by a suspend event and cleared by the matching resume;
// shared by the program and the erase flag
module suspend_flag #(
  parameter logic RESET_VAL = 1'b0
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // events from the program/erase controller
  input  wire logic set_evt,
  input  wire logic clr_evt,
  // flag state
  output logic      flag_q
);

  // set wins over clear, so a resume racing a suspend cannot hide it
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag_q <= RESET_VAL;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_evt) begin
      flag_q <= 1'b0;
    end
  end

endmodule

module cfg_regs
  import cfg_regs_pkg::*;
#(
  parameter logic RST_DIS_DEFAULT = 1'b0
)(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      resetn,
  // power-up load from the persistent store
  input  wire logic      nv_load,
  input  wire logic [7:0] nv_fn_val,
  input  wire logic [7:0] nv_rp_val,
  // decoded register writes
  input  wire reg_wr_t   reg_wr,
  // suspend and resume events
  input  wire logic      prog_suspend,
  input  wire logic      prog_resume,
  input  wire logic      erase_suspend,
  input  wire logic      erase_resume,
  // mode inputs
  input  wire logic      quad_lines_enable,
  input  wire logic      four_wire_command_mode,
  // row program request check
  input  wire logic [1:0] ir_row_sel,
  // register readback
  output logic [7:0]     func_reg,
  output logic [7:0]     read_param_work,
  output logic [7:0]     read_param_pers,
  // derived controls
  output logic           ir_program_refused,
  output logic           protect_from_bottom,
  output pin_role_t      shared_pin_role,
  output logic           wp_pin_is_data2,
  output read_cfg_t      read_cfg
);

  // ********************************************************
  // elaboration checks
  // ********************************************************
  // every field must sit inside its register byte
  if (FN_IRL_MSB >= $bits(func_reg) ||
      RP_ROLE_BIT >= $bits(read_param_work)) begin : g_chk_span
    $error("register field placed outside its byte");
  end
  // one lock bit for each row that the row index can name
  if (FN_IRL_MSB - FN_IRL_LSB + 1 !=
      2 ** $bits(ir_row_sel)) begin : g_chk_rows
    $error("lock field does not match the row index");
  end
  // dummy field must fit the decoded dummy count
  if (RP_DUMMY_MSB - RP_DUMMY_LSB + 1 !=
      $bits(DUMMY_DEFAULT)) begin : g_chk_dummy
    $error("dummy field width does not match the decode");
  end
  // burst decode covers exactly four codes
  if (RP_BURST_MSB - RP_BURST_LSB != 1) begin : g_chk_burst
    $error("burst field must be two bits wide");
  end
  // flags sit below the locks, wrap below the dummy count
  if (FN_ERASE_SUSPENDED_FLAG_BIT >= FN_IRL_LSB ||
      RP_WRAP_BIT >= RP_DUMMY_LSB) begin : g_chk_order
    $error("register fields overlap");
  end

  // ********************************************************
  // function register
  // ********************************************************
  logic [7:0] fn_q;
  logic [7:0] fn_d;
  logic [7:0] rp_work_q;
  logic [7:0] rp_pers_q;
  logic       wr_fn;
  logic       wr_pers;
  logic       wr_work;
  logic       program_suspended_flag_q;
  logic       erase_suspended_flag_q;

  assign wr_fn   = reg_wr.valid && (reg_wr.opcode == CMD_WR_FUNC);
  assign wr_pers = reg_wr.valid && (reg_wr.opcode == CMD_SRP_PERS);
  assign wr_work = reg_wr.valid && ((reg_wr.opcode == CMD_SRP_WORK0) ||
                   (reg_wr.opcode == CMD_SRP_WORK1));

  // otp bits only accumulate ones; or-ing never clears a set bit
  always_comb begin
    fn_d = fn_q;
    if (wr_fn) begin
      fn_d[FN_IRL_MSB:FN_IRL_LSB] = fn_q[FN_IRL_MSB:FN_IRL_LSB] |
        reg_wr.data[FN_IRL_MSB:FN_IRL_LSB];
      fn_d[FN_TBS_BIT] = fn_q[FN_TBS_BIT] |
        reg_wr.data[FN_TBS_BIT];
      fn_d[FN_RST_DIS_BIT] = fn_q[FN_RST_DIS_BIT] |
        reg_wr.data[FN_RST_DIS_BIT];
    end
  end

  // otp part of the function register; suspend bits are kept apart
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fn_q <= FN_RESET_VAL;
    end else if (nv_load) begin
      fn_q <= nv_fn_val | {7'h00, RST_DIS_DEFAULT};
    end else begin
      fn_q <= fn_d;
    end
  end

  // program suspend flag; set wins over resume in the same cycle
  suspend_flag #(
    .RESET_VAL (FN_RESET_VAL[FN_PROGRAM_SUSPENDED_FLAG_BIT])
  ) prog_flag (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .set_evt (prog_suspend),
    .clr_evt (prog_resume),
    .flag_q  (program_suspended_flag_q)
  );

  // erase suspend flag; host writes never reach it
  suspend_flag #(
    .RESET_VAL (FN_RESET_VAL[FN_ERASE_SUSPENDED_FLAG_BIT])
  ) erase_flag (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .set_evt (erase_suspend),
    .clr_evt (erase_resume),
    .flag_q  (erase_suspended_flag_q)
  );

  // readback merges otp and volatile fields
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      func_reg <= FN_RESET_VAL;
    end else begin
      func_reg                 <= fn_q;
      func_reg[FN_PROGRAM_SUSPENDED_FLAG_BIT]    <= program_suspended_flag_q;
      func_reg[FN_ERASE_SUSPENDED_FLAG_BIT]    <= erase_suspended_flag_q;
    end
  end

  // ********************************************************
  // read parameter register pair
  // ********************************************************

  // persistent copy, changed only by its own command
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rp_pers_q <= RP_RESET_VAL;
    end else if (nv_load) begin
      rp_pers_q <= nv_rp_val;
    end else if (wr_pers) begin
      rp_pers_q <= reg_wr.data;
    end
  end

  // working copy, loaded from the persistent value at power-up
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rp_work_q <= RP_RESET_VAL;
    end else if (nv_load) begin
      rp_work_q <= nv_rp_val;
    end else if (wr_work) begin
      rp_work_q <= reg_wr.data;
    end
  end

  // register readback
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      read_param_work <= RP_RESET_VAL;
      read_param_pers <= RP_RESET_VAL;
    end else begin
      read_param_work <= rp_work_q;
      read_param_pers <= rp_pers_q;
    end
  end

  // ********************************************************
  // derived behaviour
  // ********************************************************
  pin_role_t role_d;
  read_cfg_t cfg_d;
  logic      quad_pins;

  assign quad_pins = quad_lines_enable || four_wire_command_mode;

  // shared pin role from quad mode, reset disable and bit 7
  always_comb begin
    if (quad_pins) begin
      role_d = PIN_DATA3;
    end else if (!fn_q[FN_RST_DIS_BIT]) begin
      role_d = PIN_HOLD;
    end else if (rp_work_q[RP_ROLE_BIT]) begin
      role_d = PIN_RESET;
    end else begin
      role_d = PIN_HOLD;
    end
  end

  // read behaviour decoded from the working copy only
  always_comb begin
    cfg_d.dummy_cycles      = rp_work_q[RP_DUMMY_MSB:RP_DUMMY_LSB];
    cfg_d.use_default_dummy = (rp_work_q[RP_DUMMY_MSB:RP_DUMMY_LSB] ==
                               DUMMY_DEFAULT);
    cfg_d.wrap_in_burst     = rp_work_q[RP_WRAP_BIT];
    unique case (rp_work_q[RP_BURST_MSB:RP_BURST_LSB])
      2'b00: cfg_d.burst_bytes = BURST_8;
      2'b01: cfg_d.burst_bytes = BURST_16;
      2'b10: cfg_d.burst_bytes = BURST_32;
      2'b11: cfg_d.burst_bytes = BURST_64;
    endcase
  end

  // one lock bit per information row, picked by the row index
  logic [FN_IRL_MSB-FN_IRL_LSB:0] row_locked;

  for (genvar r = 0; r <= FN_IRL_MSB - FN_IRL_LSB; r++) begin : g_row
    assign row_locked[r] = fn_q[FN_IRL_LSB + r];
  end

  // shared and write-protect pin roles
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shared_pin_role <= PIN_HOLD;
      wp_pin_is_data2 <= 1'b0;
    end else begin
      shared_pin_role <= role_d;
      wp_pin_is_data2 <= quad_lines_enable;
    end
  end

  // protection side and row refusal follow the otp bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      protect_from_bottom <= 1'b0;
      ir_program_refused  <= 1'b0;
    end else begin
      protect_from_bottom <= fn_q[FN_TBS_BIT];
      ir_program_refused  <= row_locked[ir_row_sel];
    end
  end

  // read behaviour; persistent writes wait for the next power-up load
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      read_cfg <= '0;
    end else begin
      read_cfg <= cfg_d;
    end
  end

endmodule

// ### tb/cfg_regs_props.sv
// checker: port relations of cfg_regs
// assumes: bound to every cfg_regs by the line after the module
`timescale 1ns/1ps

module cfg_regs_props
  import cfg_regs_pkg::*;
(
  // clock, reset and inputs
  input wire logic       clk_sys, resetn, nv_load,
  input wire logic [7:0] nv_fn_val, nv_rp_val,
  input wire reg_wr_t    reg_wr,
  input wire logic       prog_suspend, prog_resume,
  input wire logic       erase_suspend, erase_resume,
  input wire logic       quad_lines_enable, four_wire_command_mode,
  input wire logic [1:0] ir_row_sel,
  // outputs
  input wire logic [7:0] func_reg, read_param_work, read_param_pers,
  input wire logic       ir_program_refused, protect_from_bottom,
  input wire pin_role_t  shared_pin_role,
  input wire logic       wp_pin_is_data2,
  input wire read_cfg_t  read_cfg
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic wr_ok;
  logic quad_or_qpi;
  // a write not overridden by a power-up load in the same cycle
  assign wr_ok = reg_wr.valid && !nv_load;
  assign quad_or_qpi = quad_lines_enable || four_wire_command_mode;

  work_write_a: assert property (
    wr_ok && (reg_wr.opcode == CMD_SRP_WORK0 ||
    reg_wr.opcode == CMD_SRP_WORK1) |-> ##2
    read_param_work == $past(reg_wr.data, 2))
    else $error("working copy missed a write");
  pers_write_a: assert property (
    wr_ok && reg_wr.opcode == CMD_SRP_PERS |-> ##2
    read_param_pers == $past(reg_wr.data, 2))
    else $error("persistent copy missed a write");
  otp_sticky_a: assert property (
    !nv_load && !$past(nv_load) |=>
    (func_reg & $past(func_reg) & 8'hf3) == ($past(func_reg) & 8'hf3))
    else $error("one-time bit cleared");
  prog_susp_a: assert property (
    prog_suspend && !nv_load |-> ##2 func_reg[FN_PROGRAM_SUSPENDED_FLAG_BIT])
    else $error("program suspend flag not set");
  erase_resume_a: assert property (
    erase_resume && !erase_suspend && !nv_load |-> ##2
    !func_reg[FN_ERASE_SUSPENDED_FLAG_BIT])
    else $error("erase suspend flag not cleared");
  pin_data3_a: assert property (
    quad_or_qpi [*3] |-> shared_pin_role == PIN_DATA3)
    else $error("shared pin is not a data line");
  pin_hold_a: assert property (
    (!quad_or_qpi && !func_reg[FN_RST_DIS_BIT]) [*3] |->
    shared_pin_role == PIN_HOLD)
    else $error("shared pin is not hold");
  wp_data2_a: assert property (
    $stable(quad_lines_enable) [*3] |->
    wp_pin_is_data2 == quad_lines_enable)
    else $error("write-protect pin role wrong");
  row_lock_a: assert property (
    $stable(ir_row_sel) [*3] |->
    ir_program_refused == func_reg[FN_IRL_LSB + ir_row_sel])
    else $error("row lock not applied");
  cfg_follow_a: assert property (
    $past(resetn) && $past(resetn, 2) |->
    read_cfg == {read_param_work[6:3], read_param_work[6:3] == 4'h0,
    read_param_work[2], 7'h08 << read_param_work[1:0]})
    else $error("read behaviour not from working copy");
endmodule

bind cfg_regs cfg_regs_props chk (
  .clk_sys                (clk_sys),
  .resetn                 (resetn),
  .nv_load                (nv_load),
  .nv_fn_val              (nv_fn_val),
  .nv_rp_val              (nv_rp_val),
  .reg_wr                 (reg_wr),
  .prog_suspend           (prog_suspend),
  .prog_resume            (prog_resume),
  .erase_suspend          (erase_suspend),
  .erase_resume           (erase_resume),
  .quad_lines_enable      (quad_lines_enable),
  .four_wire_command_mode (four_wire_command_mode),
  .ir_row_sel             (ir_row_sel),
  .func_reg               (func_reg),
  .read_param_work        (read_param_work),
  .read_param_pers        (read_param_pers),
  .ir_program_refused     (ir_program_refused),
  .protect_from_bottom    (protect_from_bottom),
  .shared_pin_role        (shared_pin_role),
  .wp_pin_is_data2        (wp_pin_is_data2),
  .read_cfg               (read_cfg)
);

// ### tb/host_model.sv
// model: host controller side issuing decoded register writes
// assumes: go, op and dat change just after a falling edge
`timescale 1ns/1ps

module host_model
  import cfg_regs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic [7:0] op,
  input  wire logic [7:0] dat,
  output reg_wr_t         reg_wr
);
  logic [15:0] last_q = 16'h5aa5;
  // remember the last command so idle fields never repeat it
  always_ff @(posedge clk_sys) begin
    if (go) begin
      last_q <= {op, dat};
    end
  end
  // one-cycle command; opcode picks which copy is addressed
  always_comb begin
    reg_wr = go ? {1'b1, op, dat} : {1'b0, ~last_q};
  end
endmodule

// ### tb/test_cfg_regs.sv
// bench: cfg_regs behind a host model; table rows, then hand cases
// assumes: the checker is bound to cfg_regs
`timescale 1ns/1ps

module test_cfg_regs
  import cfg_regs_pkg::*;
;
  typedef struct packed {
    logic [7:0] op, d, ew, ep;
  } row_t;
  logic       clk_sys, resetn, nv_load, go, wp_pin_is_data2;
  logic       prog_suspend, prog_resume, erase_suspend, erase_resume;
  logic       quad_lines_enable, four_wire_command_mode;
  logic       ir_program_refused, protect_from_bottom;
  logic [1:0] ir_row_sel;
  logic [7:0] op, dat, nv_fn_val, nv_rp_val;
  logic [7:0] func_reg, read_param_work, read_param_pers;
  reg_wr_t    reg_wr;
  pin_role_t  shared_pin_role;
  read_cfg_t  read_cfg;
  int         err_count, cmp_count, cyc;
  row_t       rows [7] = '{'{CMD_SRP_WORK0, 8'h00, 8'h00, 8'h00},
    '{CMD_SRP_WORK0, 8'h0d, 8'h0d, 8'h00},
    '{CMD_SRP_WORK1, 8'h7e, 8'h7e, 8'h00},
    '{CMD_SRP_PERS, 8'h33, 8'h7e, 8'h33},
    '{8'h01, 8'hff, 8'h7e, 8'h33},
    '{CMD_SRP_WORK1, 8'hfb, 8'hfb, 8'h33},
    '{CMD_SRP_PERS, 8'h00, 8'hfb, 8'h00}};

  cfg_regs dut (
    .clk_sys                (clk_sys),
    .resetn                 (resetn),
    .nv_load                (nv_load),
    .nv_fn_val              (nv_fn_val),
    .nv_rp_val              (nv_rp_val),
    .reg_wr                 (reg_wr),
    .prog_suspend           (prog_suspend),
    .prog_resume            (prog_resume),
    .erase_suspend          (erase_suspend),
    .erase_resume           (erase_resume),
    .quad_lines_enable      (quad_lines_enable),
    .four_wire_command_mode (four_wire_command_mode),
    .ir_row_sel             (ir_row_sel),
    .func_reg               (func_reg),
    .read_param_work        (read_param_work),
    .read_param_pers        (read_param_pers),
    .ir_program_refused     (ir_program_refused),
    .protect_from_bottom    (protect_from_bottom),
    .shared_pin_role        (shared_pin_role),
    .wp_pin_is_data2        (wp_pin_is_data2),
    .read_cfg               (read_cfg)
  );
  host_model host (.clk_sys, .go, .op, .dat, .reg_wr);

  // ****************************************
  // clock, timeout and helper tasks
  // ****************************************
  always #20 clk_sys = ~clk_sys;
  // ceiling: the sequence needs about 82 cycles, 1000 leaves margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(logic [15:0] g, logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one-cycle pulse, then let the two-edge latency pass
  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic wr(logic [7:0] o, logic [7:0] v);
    op = o;
    dat = v;
    pulse(go);
  endtask
  function automatic logic [12:0] cfg_of(logic [7:0] p);
    return {p[6:3], p[6:3] == 4'h0, p[2], 7'h08 << p[1:0]};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {clk_sys, resetn, nv_load, go, op, dat, nv_fn_val} = '0;
    {prog_suspend, prog_resume, erase_suspend, erase_resume} = '0;
    {quad_lines_enable, four_wire_command_mode, nv_rp_val} = '0;
    ir_row_sel = 2'h1;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    chk(func_reg, FN_RESET_VAL);
    chk(read_param_work, RP_RESET_VAL);
    foreach (rows[i]) begin
      wr(rows[i].op, rows[i].d);
      chk(read_param_work, rows[i].ew);
      chk(read_param_pers, rows[i].ep);
      chk(read_cfg, cfg_of(rows[i].ew));
      chk(shared_pin_role, PIN_HOLD);
    end
    nv_rp_val = 8'h5a;
    nv_fn_val = 8'h0c;
    pulse(nv_load);
    chk(func_reg, 8'h00);
    chk(read_param_work, 8'h5a);
    chk(read_param_pers, 8'h5a);
    wr(CMD_WR_FUNC, 8'h1e);
    chk(func_reg, 8'h12);
    chk(protect_from_bottom, 1'b1);
    chk(ir_program_refused, 1'b0);
    ir_row_sel = 2'h0;
    repeat (2) @(negedge clk_sys);
    chk(ir_program_refused, 1'b1);
    ir_row_sel = 2'h1;
    wr(CMD_WR_FUNC, 8'he1);
    chk(func_reg, 8'hf3);
    chk(ir_program_refused, 1'b1);
    chk(shared_pin_role, PIN_HOLD);
    wr(CMD_SRP_WORK0, 8'h80);
    chk(shared_pin_role, PIN_RESET);
    quad_lines_enable = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(shared_pin_role, PIN_DATA3);
    chk(wp_pin_is_data2, 1'b1);
    quad_lines_enable = 1'b0;
    four_wire_command_mode = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(shared_pin_role, PIN_DATA3);
    chk(wp_pin_is_data2, 1'b0);
    four_wire_command_mode = 1'b0;
    pulse(prog_suspend);
    chk(func_reg, 8'hf7);
    pulse(erase_suspend);
    chk(func_reg, 8'hff);
    pulse(prog_resume);
    chk(func_reg, 8'hfb);
    pulse(erase_resume);
    chk(func_reg, 8'hf3);
    // suspend and resume in one cycle: the suspend wins
    @(negedge clk_sys);
    {erase_suspend, erase_resume} = 2'b11;
    @(negedge clk_sys);
    {erase_suspend, erase_resume} = 2'b00;
    repeat (2) @(negedge clk_sys);
    chk(func_reg, 8'hfb);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    chk(read_param_work, RP_RESET_VAL);
    chk(shared_pin_role, PIN_HOLD);
    wr(CMD_SRP_WORK1, 8'h11);
    chk(read_param_work, 8'h11);
    chk(func_reg, FN_RESET_VAL);
    results();
  end
endmodule
